// ===== tss_pkg.sv
// package of constants and types for the temperature sensor serial slave
package tss_pkg;
  localparam int          TSS_WORD_BITS     = 16;
  localparam int          TSS_TEMP_BITS     = 14;
  localparam int          TSS_CMD_BITS      = 8;
  localparam int          TSS_RX_BITS       = 16;
  localparam logic [7:0]  TSS_CMD_SHUTDOWN  = 8'hff;
  localparam logic [7:0]  TSS_CMD_CONVERT   = 8'h00;
  localparam logic [1:0]  TSS_LOW_ONES      = 2'h3;
  localparam int          TSS_MFR_BITS      = 5;
  // identification value is arbitrary
  localparam logic [15:0] TSS_ID_DEFAULT    = 16'ha5c3;
  localparam int          TSS_CONV_MS       = 270;
  localparam int          TSS_CLK_MHZ       = 125;
  localparam int          TSS_CONV_CYCLES   = TSS_CONV_MS * 1000 * TSS_CLK_MHZ;

  typedef enum logic [1:0] {
    TSS_IDLE = 2'b00,
    TSS_TX   = 2'b01,
    TSS_RX   = 2'b10,
    TSS_DONE = 2'b11
  } tss_state_t;

  typedef enum logic [0:0] {
    TSS_MODE_CONV = 1'b0,
    TSS_MODE_SHDN = 1'b1
  } tss_mode_t;

  // serial pin group as seen by the core after synchronisation
  typedef struct packed {
    logic cs_b;
    logic clk;
    logic din;
  } tss_pins_t;
endpackage

// ===== tss_serial_slave.sv
// serial slave and mode control of a digital temperature sensor
`timescale 1ns/1ps
// Operation
// [RULE_01] powers up in continuous conversion mode
// [RULE_02] temperature invalid until first conversion done
// [RULE_03] power-on reset restores all defaults
// [RULE_04] shift out on fall, sample on rise
// [RULE_05] 16 clocks transmit then 16 receive
// [RULE_06] data pin released while select high
// [RULE_07] first bit driven when select falls
// [RULE_08] host never lowers select on rising clock
// [RULE_09] select may rise anytime during transmit
// [RULE_10] new result loaded only after select rises
// [RULE_11] last eight received bits form command
// [RULE_12] ones shut down, zeros resume conversion
// [RULE_13] host sends only all-zeros or all-ones
// [RULE_14] shutdown keeps bus, sends identification word
// [RULE_15] top five id bits are manufacturer
// [RULE_16] 14-bit two's complement temperature, upper bits
// [RULE_17] most significant bit sent first
// [RULE_18] chained read, shutdown, id, convert supported
// [RULE_19] host waits after returning to conversion
// [RULE_20] mode write-only, data words read-only
// [RULE_21] two low bits always driven one
// [RULE_22] host spaces reads by conversion time
// [RULE_23] shift register loaded at select fall
// [RULE_24] mode updates when select rises
module tss_serial_slave
  import tss_pkg::*;
#(
  parameter int          CONV_CYCLES = TSS_CONV_CYCLES,
  parameter logic [15:0] ID_WORD     = TSS_ID_DEFAULT
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // converter side
  input  wire logic [TSS_TEMP_BITS-1:0] conv_temp,
  output logic                          conv_active,
  output logic                          temp_valid,
  output logic                          shutdown,
  // serial pins
  input  wire logic                     chip_sel_b,
  input  wire logic                     serial_clock_in,
  input  wire logic                     sio_in,
  output logic                          sio_out,
  output logic                          sio_oe_b
);

  // three-flop chains on the pin inputs; edges compare the second and third flops
  tss_pins_t s1_reg, s2_reg, s3_reg;
  tss_pins_t s1_next, s2_next, s3_next;

  always_comb begin
    s1_next = '{cs_b: chip_sel_b, clk: serial_clock_in, din: sio_in};
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '{cs_b: 1'b1, clk: 1'b0, din: 1'b0};
      s2_reg <= '{cs_b: 1'b1, clk: 1'b0, din: 1'b0};
      s3_reg <= '{cs_b: 1'b1, clk: 1'b0, din: 1'b0};
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  logic sc_rise, sc_fall, cs_fall, cs_rise, sel;
  assign sc_rise = s2_reg.clk & ~s3_reg.clk;
  assign sc_fall = ~s2_reg.clk & s3_reg.clk;
  assign cs_fall = ~s2_reg.cs_b & s3_reg.cs_b;
  assign cs_rise = s2_reg.cs_b & ~s3_reg.cs_b;
  assign sel     = ~s2_reg.cs_b;

  // converter timer and result holding
  localparam int CW = $clog2(CONV_CYCLES + 1);
  logic [CW-1:0]              conv_cnt_reg, conv_cnt_next;
  logic [TSS_TEMP_BITS-1:0]   result_reg, result_next;
  logic [TSS_TEMP_BITS-1:0]   pend_reg, pend_next;
  logic                       pend_flag_reg, pend_flag_next;
  logic                       valid_reg, valid_next;
  tss_mode_t                  mode_reg, mode_next;

  // serial transfer state
  tss_state_t                 st_reg, st_next;
  logic [TSS_WORD_BITS-1:0]   shift_reg, shift_next;
  logic [4:0]                 bit_cnt_reg, bit_cnt_next;
  logic [TSS_CMD_BITS-1:0]    cmd_reg, cmd_next;
  logic [4:0]                 rx_cnt_reg, rx_cnt_next;
  logic                       out_reg, out_next;
  logic                       oe_b_reg, oe_b_next;

  logic                       conv_done;
  logic [TSS_WORD_BITS-1:0]   load_word;
  assign conv_done = (mode_reg == TSS_MODE_CONV) && (conv_cnt_reg == CW'(CONV_CYCLES - 1));

  always_comb begin
    // [RULE_14] [RULE_15] [RULE_16] [RULE_21]
    // follows the mode being decoded, so a chained shutdown sends the id word at once
    if (mode_next == TSS_MODE_SHDN)
      load_word = {ID_WORD[15:2], TSS_LOW_ONES};
    else
      load_word = {result_reg, TSS_LOW_ONES};
  end

  // converter group
  always_comb begin
    conv_cnt_next  = conv_cnt_reg;
    result_next    = result_reg;
    pend_next      = pend_reg;
    pend_flag_next = pend_flag_reg;
    valid_next     = valid_reg;
    if (mode_reg == TSS_MODE_SHDN) begin
      conv_cnt_next = '0;
    end else if (conv_done) begin
      conv_cnt_next = '0;
      valid_next    = 1'b1; // [RULE_02]
      if (sel) begin
        pend_next      = conv_temp; // [RULE_10]
        pend_flag_next = 1'b1;
      end else begin
        // a newer result supersedes any value parked during the last frame
        result_next    = conv_temp;
        pend_flag_next = 1'b0;
      end
    end else begin
      conv_cnt_next = conv_cnt_reg + CW'(1);
    end
    if (!sel && pend_flag_reg && !conv_done) begin
      result_next    = pend_reg; // [RULE_10]
      pend_flag_next = 1'b0;
    end
  end

  // command decode: select rise, or the fall that ends a chained receive phase
  logic decode_now, cmd_full;
  always_comb begin
    decode_now = cs_rise || (sel && !cs_fall && st_reg == TSS_DONE && sc_fall); // [RULE_18] [RULE_24]
    cmd_full   = (rx_cnt_reg >= 5'(TSS_CMD_BITS)); // [RULE_11]
  end

  // mode group
  always_comb begin
    mode_next = mode_reg;
    // unknown codes keep the mode rather than guess at a test pattern
    if (decode_now && cmd_full) begin
      if (cmd_reg == TSS_CMD_SHUTDOWN)
        mode_next = TSS_MODE_SHDN; // [RULE_12]
      else if (cmd_reg == TSS_CMD_CONVERT)
        mode_next = TSS_MODE_CONV; // [RULE_12]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= TSS_MODE_CONV; // [RULE_01] [RULE_03]
    end else begin
      mode_reg <= mode_next;
    end
  end

  // serial group
  always_comb begin
    st_next      = st_reg;
    shift_next   = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    cmd_next     = cmd_reg;
    rx_cnt_next  = rx_cnt_reg;
    out_next     = out_reg;
    if (cs_rise || !sel) begin
      // [RULE_09] deselect ends any phase; the mode group decodes the byte
      st_next     = TSS_IDLE;
      rx_cnt_next = '0;
    end else if (cs_fall) begin
      shift_next   = {load_word[TSS_WORD_BITS-2:0], 1'b1}; // [RULE_23]
      out_next     = load_word[TSS_WORD_BITS-1]; // [RULE_07] [RULE_17]
      bit_cnt_next = '0;
      rx_cnt_next  = '0;
      st_next      = TSS_TX;
    end else begin
      case (st_reg)
        TSS_TX: begin
          if (sc_rise) begin
            bit_cnt_next = bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == 5'(TSS_WORD_BITS - 1)) begin
              st_next      = TSS_RX; // [RULE_05]
              bit_cnt_next = '0;
            end
          end else if (sc_fall && bit_cnt_reg != 5'd0) begin
            out_next   = shift_reg[TSS_WORD_BITS-1]; // [RULE_04]
            shift_next = {shift_reg[TSS_WORD_BITS-2:0], 1'b1};
          end
        end
        TSS_RX: begin
          if (sc_rise) begin
            cmd_next     = {cmd_reg[TSS_CMD_BITS-2:0], s2_reg.din}; // [RULE_04] [RULE_11]
            bit_cnt_next = bit_cnt_reg + 5'd1;
            if (rx_cnt_reg < 5'd8)
              rx_cnt_next = rx_cnt_reg + 5'd1;
            if (bit_cnt_reg == 5'(TSS_RX_BITS - 1))
              st_next = TSS_DONE;
          end
        end
        TSS_DONE: begin
          // [RULE_18] a chained frame starts again with a fresh word
          if (sc_fall) begin
            shift_next   = {load_word[TSS_WORD_BITS-2:0], 1'b1};
            out_next     = load_word[TSS_WORD_BITS-1];
            bit_cnt_next = '0;
            rx_cnt_next  = '0;
            st_next      = TSS_TX;
          end
        end
        default: st_next = TSS_IDLE;
      endcase
    end
    // registered so the pin enable never glitches between phases
    oe_b_next = ~(sel && st_next == TSS_TX); // [RULE_06]
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // [RULE_02] [RULE_03] converter restarts, output word invalid
      valid_reg     <= 1'b0;
      conv_cnt_reg  <= '0;
      result_reg    <= '0;
      pend_reg      <= '0;
      pend_flag_reg <= 1'b0;
    end else begin
      valid_reg     <= valid_next;
      conv_cnt_reg  <= conv_cnt_next;
      result_reg    <= result_next;
      pend_reg      <= pend_next;
      pend_flag_reg <= pend_flag_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // [RULE_03] [RULE_06] link idles with the pin released
      st_reg        <= TSS_IDLE;
      shift_reg     <= '1;
      bit_cnt_reg   <= '0;
      cmd_reg       <= '0;
      rx_cnt_reg    <= '0;
      out_reg       <= 1'b1;
      oe_b_reg      <= 1'b1;
    end else begin
      st_reg        <= st_next;
      shift_reg     <= shift_next;
      bit_cnt_reg   <= bit_cnt_next;
      cmd_reg       <= cmd_next;
      rx_cnt_reg    <= rx_cnt_next;
      out_reg       <= out_next;
      oe_b_reg      <= oe_b_next;
    end
  end

  // [RULE_06] [RULE_20] pin only driven during transmit phase
  assign sio_out     = out_reg;
  assign sio_oe_b    = oe_b_reg;
  assign conv_active = (mode_reg == TSS_MODE_CONV);
  assign temp_valid  = valid_reg;
  assign shutdown    = (mode_reg == TSS_MODE_SHDN);

endmodule // tss_serial_slave

// ===== tss_serial_slave_asserts.sv
// assertion checker for the temperature sensor serial slave
`timescale 1ns/1ps
module tss_serial_slave_asserts (
  // clock and reset
  input logic core_clk,
  input logic rst_b,
  // mode flags and serial pins
  input logic conv_active,
  input logic temp_valid,
  input logic shutdown,
  input logic chip_sel_b,
  input logic serial_clock_in,
  input logic sio_out,
  input logic sio_oe_b
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_mode; conv_active != shutdown; endproperty
  a_mode: assert property (p_mode) else $error("mode flags clash");
  property p_idle; chip_sel_b [*6] |-> sio_oe_b; endproperty
  a_idle: assert property (p_idle) else $error("pin driven while idle");
  property p_first; $fell(chip_sel_b) |-> ##[2:6] !sio_oe_b; endproperty
  a_first: assert property (p_first) else $error("first bit late");
  property p_hold; (serial_clock_in && !sio_oe_b) [*4] |-> $stable(sio_out); endproperty
  a_hold: assert property (p_hold) else $error("bit moved in high clock");
  property p_abort; $rose(chip_sel_b) |-> ##[1:6] sio_oe_b; endproperty
  a_abort: assert property (p_abort) else $error("pin kept after deselect");
  property p_upd; $changed(shutdown) |-> !$past(serial_clock_in, 2); endproperty
  a_upd: assert property (p_upd) else $error("mode moved mid bit");
  property p_valid; temp_valid |=> temp_valid; endproperty
  a_valid: assert property (p_valid) else $error("valid dropped");
  property p_vrise; $rose(temp_valid) |-> $past(conv_active); endproperty
  a_vrise: assert property (p_vrise) else $error("valid in shutdown");
  property p_boot; $rose(rst_b) |-> conv_active && !shutdown && !temp_valid && sio_oe_b; endproperty
  a_boot: assert property (p_boot) else $error("reset defaults wrong");
  c_shdn: cover property ($rose(shutdown));
  c_wake: cover property ($fell(shutdown));
  c_abort: cover property ($rose(chip_sel_b) && $past(!sio_oe_b));
endmodule // tss_serial_slave_asserts

bind tss_serial_slave tss_serial_slave_asserts u_chk (.*);

// ===== tss_host_model.sv
// host model that drives the sensor's serial pins
`timescale 1ns/1ps
module tss_host_model (
  // clock
  input  logic clk,
  // serial pins
  output logic chip_sel_b = 1'b1,
  output logic serial_clock_in = 1'b0,
  output logic host_d,
  input  logic sio_in
);
  logic drv = 1'b0;
  logic bit_d = 1'b0;
  logic tog = 1'b0;
  // a released line toggles so a stale bit never reads as data
  assign host_d = drv ? bit_d : tog;
  always @(posedge clk) tog <= ~tog;
  task automatic xfer(input int nb, input logic [63:0] wr, output logic [63:0] rd);
    rd = '0;
    @(posedge clk);
    chip_sel_b <= 1'b0; // only while the clock idles low
    for (int i = 0; i < nb; i++) begin // 16 out, then up to 16 in, repeating every 32
      drv <= (i % 32) >= 16;
      bit_d <= wr[63-i];
      // five low and five high core clocks give the 80 ns link period
      repeat (4) @(posedge clk);
      @(negedge clk);
      rd[63-i] = sio_in;
      @(posedge clk);
      serial_clock_in <= 1'b1;
      repeat (5) @(posedge clk);
      serial_clock_in <= 1'b0;
    end
    repeat (3) @(posedge clk);
    chip_sel_b <= 1'b1;
    drv <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // tss_host_model

// ===== tb.sv
// self-checking bench for the temperature sensor serial slave
`timescale 1ns/1ps
module tb;
  import tss_pkg::*;
  localparam logic [15:0] ID_EXP = {TSS_ID_DEFAULT[15:2], TSS_LOW_ONES};
  logic                     core_clk = 1'b0;
  logic                     rst_b = 1'b0;
  logic [TSS_TEMP_BITS-1:0] conv_temp = 14'h12c0;
  logic                     conv_active, temp_valid, shutdown, chip_sel_b, serial_clock_in;
  logic                     host_d, sio_in, sio_out, sio_oe_b;
  logic [63:0]              rd;
  int                       n_errors = 0;
  int                       total_checks = 0;
  always #4 core_clk = ~core_clk;
  assign sio_in = sio_oe_b ? host_d : sio_out;
  tss_serial_slave #(.CONV_CYCLES(200), .ID_WORD(TSS_ID_DEFAULT)) dut (.*);
  tss_host_model host (.clk(core_clk), .*);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic frame(input int nb, input logic [31:0] w);
    host.xfer(nb, {16'h0, w, 16'h0}, rd);
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({conv_active, shutdown, temp_valid, sio_oe_b}, 4'h9);
  endtask
  initial begin
    do_reset;
    for (int k = 0; k < 1000 && temp_valid !== 1'b1; k++)
      @(posedge core_clk);
    if (temp_valid !== 1'b1) begin
      chk(temp_valid, 1'b1);
    end else begin
      frame(16, 32'h0);
      chk(rd[63:48], {14'h12c0, TSS_LOW_ONES});
      frame(4, 32'h0);
      chk({rd[63:60], sio_oe_b}, 5'h09);
      conv_temp <= 14'h3b00;
      frame(32, 32'h0); // only the two defined codes are sent
      frame(16, 32'h0);
      chk(rd[63:48], {14'h3b00, TSS_LOW_ONES});
      frame(32, 32'h00ff_0000);
      chk({shutdown, conv_active}, 2'h2);
      frame(16, 32'h0);
      chk(rd[63:48], ID_EXP);
      frame(32, 32'hff00_0000);
      chk(shutdown, 1'b0);
      repeat (300) @(posedge core_clk);
      frame(56, 32'hffff_0000);
      chk({rd[63:48], rd[31:16], shutdown}, {14'h3b00, TSS_LOW_ONES, ID_EXP, 1'b0});
      frame(32, 32'h00ff_0000);
      do_reset;
    end
    report_and_stop;
  end
endmodule // tb
